/* File: hbs_map.svh */
// Constants of the half-bridge serial control block: command and status
// bit positions and timing counts.
// Assumes a 200 MHz system clock; included by bare name.
`ifndef HBS_MAP_SVH
`define HBS_MAP_SVH
// Command word fields
`define HBS_CMD_SRR      15
`define HBS_CMD_GRP      14
`define HBS_CMD_ULD      13
`define HBS_CMD_EN_LSB   7
`define HBS_CMD_SIDE_LSB 1
`define HBS_CMD_OVERVOLTAGE_LOCKOUT_ENABLE     0
// Status word fields
`define HBS_ST_OCS       15
`define HBS_ST_PSF       14
`define HBS_ST_ULD       13
`define HBS_ST_EN_LSB    7
`define HBS_ST_SIDE_LSB  1
`define HBS_ST_TW        0
// Channel groups
`define HBS_NUM_BRIDGES  8
`define HBS_LOW_COUNT    6
`define HBS_HIGH_COUNT   2
`define HBS_WORD_BITS    16
// Timing
`define HBS_CLK_MHZ      200
`define HBS_POR_US       100
`define HBS_POR_CYCLES   (`HBS_POR_US * `HBS_CLK_MHZ)
`endif

/* File: hbs_pkg.sv */
// Types of the half-bridge serial control block.
// Assumes the field constants of hbs_map.svh.
package hbs_pkg;
  // Power phase after the enable pin
  typedef enum logic [1:0] {PH_SLEEP, PH_POR, PH_RUN} hbs_phase_t;

  // Whole state of the top module
  typedef struct packed {
    hbs_phase_t  phase;    // Sleep, reset wait or running
    logic [15:0] por_cnt;  // Reset wait counter
    logic        sclk_d;   // Previous serial clock sample
    logic        csn_d;    // Previous chip select sample
    logic        in_frame; // Frame in progress
    logic [7:0]  bit_cnt;  // Falling clock edges in frame
    logic [15:0] rx;       // Received bits
    logic [15:0] tx;       // Outgoing status bits
    logic [15:0] cmd;      // Last accepted command word
    logic        sdo;      // Serial output level
    logic        sdo_oe;   // Serial output driven
    logic        tsd_lat;  // Latched thermal shutdown
    logic        load;     // Command applied this cycle
    logic        awake;    // Running phase, drives the awake pin
  } hbs_top_state_t;
endpackage : hbs_pkg

/* File: hbs_sync.sv */
// Two flip-flop synchroniser for a bundle of asynchronous inputs.
// Assumes each bit is a level that changes slowly against clk.
`timescale 1ns/1ps
module hbs_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  // Both stages as one state
  typedef struct packed {
    logic [W-1:0] meta; // First stage, read only by second
    logic [W-1:0] stab; // Second stage, safe to use
  } hbs_sync_state_t;

  hbs_sync_state_t s_r;
  hbs_sync_state_t s_nxt;

  // Next state: shift through both stages
  always_comb
  begin
    s_nxt      = s_r;
    s_nxt.meta = async_in;
    s_nxt.stab = s_r.meta;
  end

  // Registers
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign sync_out = s_r.stab;
endmodule : hbs_sync

/* File: hbs_bridge.sv */
// One half-bridge channel: enable, side, fault latches and drive.
// Assumes fault inputs already synchronised and one-cycle load pulses.
`timescale 1ns/1ps
module hbs_bridge (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic sleep,       // Clear everything
  input  wire logic load,        // Apply command bits
  input  wire logic en_in,       // Output enable bit
  input  wire logic side_in,     // Side configuration bit
  input  wire logic uld_arm_in,  // Underload shutdown arm bit
  input  wire logic status_reset_request,         // Status reset request
  input  wire logic oc_det,      // Overcurrent present
  input  wire logic ul_det,      // Underload present
  input  wire logic lockout,     // Global lockout
  output logic      hs_on,
  output logic      ls_on,
  output logic      en_status,
  output logic      side_status,
  output logic      oc_flag,
  output logic      ul_flag
);
  // Channel state
  typedef struct packed {
    logic en;     // Programmed enable
    logic side;   // Programmed side
    logic arm;    // Underload shutdown armed
    logic oc;     // Latched overcurrent
    logic ul;     // Latched underload
    logic active; // Channel driving
    logic hs;     // High side on
    logic ls;     // Low side on
  } hbs_bridge_state_t;

  hbs_bridge_state_t s_r;
  hbs_bridge_state_t s_nxt;

  // Next state
  always_comb
  begin
    s_nxt = s_r;
    if (sleep)
      s_nxt = '0;
    else
    begin
      // New programming
      if (load)
      begin
        s_nxt.en   = en_in;
        s_nxt.side = side_in;
        s_nxt.arm  = uld_arm_in;
      end
      // Status reset only clears a fault that has gone
      if (status_reset_request && !oc_det)
        s_nxt.oc = 1'b0;
      if (status_reset_request && !ul_det)
        s_nxt.ul = 1'b0;
      // A present fault wins over the clear
      if (oc_det)
        s_nxt.oc = 1'b1;
      if (ul_det)
        s_nxt.ul = 1'b1;
      // Shut down drops the enable; must be re-programmed
      if (s_nxt.oc || (s_nxt.ul && s_nxt.arm))
        s_nxt.en = 1'b0;
      s_nxt.active = s_nxt.en && !lockout;
      // Exactly one side conducts while active
      s_nxt.hs = s_nxt.active && s_nxt.side;
      s_nxt.ls = s_nxt.active && !s_nxt.side;
    end
  end

  // Registers
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign hs_on       = s_r.hs;
  assign ls_on       = s_r.ls;
  assign en_status   = s_r.active;
  assign side_status = s_r.hs; // Zero whenever not active
  assign oc_flag     = s_r.oc;
  assign ul_flag     = s_r.ul;
endmodule : hbs_bridge

/* File: hbs_top.sv */
// Serial command and status port of an eight channel half-bridge driver.
// Assumes asynchronous pins and fault detectors; all are synchronised.
`timescale 1ns/1ps
`include "hbs_map.svh"
module hbs_top #(
  parameter int POR_CYCLES = `HBS_POR_CYCLES // Wait after enable rises
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       enable,          // Enable pin, active high
  input  wire logic       chip_select_n,   // Frame select, active low
  input  wire logic       sclk,            // Serial clock pin
  input  wire logic       sdi,             // Serial data in
  input  wire logic       tsd_det,         // Thermal shutdown detector
  input  wire logic       tw_det,          // Thermal warning detector
  input  wire logic       uv_det,          // Supply undervoltage
  input  wire logic       ov_det,          // Supply overvoltage
  input  wire logic [7:0] oc_det,          // Overcurrent per bridge
  input  wire logic [7:0] ul_det,          // Underload per bridge
  output logic            sdo,             // Serial data out
  output logic            sdo_oe,          // Serial output driven
  output logic [7:0]      high_side_on,    // High side switch drive
  output logic [7:0]      low_side_on,     // Low side switch drive
  output logic            awake            // Serial port serviced
);
  localparam int NB = `HBS_NUM_BRIDGES;
  localparam int SW = 8 + NB + NB; // Synchronised input count

  // Synchronised inputs
  logic [SW-1:0] pins_s;
  logic          en_s;
  logic          csn_s;
  logic          sclk_s;
  logic          sdi_s;
  logic          tsd_s;
  logic          tw_s;
  logic          uv_s;
  logic          ov_s;
  logic [NB-1:0] oc_s;
  logic [NB-1:0] ul_s;

  // Bridge status
  logic [NB-1:0] en_st;
  logic [NB-1:0] side_st;
  logic [NB-1:0] oc_fl;
  logic [NB-1:0] ul_fl;
  logic          lockout;   // All outputs off
  logic          srr_pulse; // Status reset this cycle
  logic [15:0]   status;    // Word for the selected group

  hbs_pkg::hbs_top_state_t s_r;
  hbs_pkg::hbs_top_state_t s_nxt;

  // Edge and frame conditions
  logic csn_fall;
  logic csn_rise;
  logic sclk_rise;
  logic sclk_fall;
  logic frame_ok;

  // Every pin passes two flip-flops
  hbs_sync #(
    .W (SW)
  ) u_sync (
    .clk      (clk),
    .rst_n    (rst_n),
    .async_in ({enable, chip_select_n, sclk, sdi, tsd_det, tw_det,
                uv_det, ov_det, oc_det, ul_det}),
    .sync_out (pins_s)
  );

  assign {en_s, csn_s, sclk_s, sdi_s, tsd_s, tw_s, uv_s, ov_s, oc_s, ul_s}
    = pins_s;

  assign csn_fall  = s_r.csn_d && !csn_s;
  assign csn_rise  = !s_r.csn_d && csn_s;
  assign sclk_rise = !s_r.sclk_d && sclk_s;
  assign sclk_fall = s_r.sclk_d && !sclk_s;
  // Accept whole multiples of eight bits, from one word up to 248 bits (count saturates at 255)
  assign frame_ok  = (s_r.bit_cnt >= 8'(`HBS_WORD_BITS))
                     && (s_r.bit_cnt[2:0] == 3'h0)
                     && (s_r.bit_cnt != 8'hFF);

  // Supply fault, lockout and status reset
  assign srr_pulse = s_r.load && s_r.cmd[`HBS_CMD_SRR];
  assign lockout   = s_r.tsd_lat || uv_s
                     || (s_r.cmd[`HBS_CMD_OVERVOLTAGE_LOCKOUT_ENABLE] && ov_s);

  // Status word of the group named by the last command
  always_comb
  begin
    status = 16'h0000;
    status[`HBS_ST_PSF] = uv_s || ov_s;
    status[`HBS_ST_TW]  = tw_s;
    if (s_r.cmd[`HBS_CMD_GRP])
    begin
      status[`HBS_ST_OCS] = |oc_fl[NB-1:`HBS_LOW_COUNT];
      status[`HBS_ST_ULD] = |ul_fl[NB-1:`HBS_LOW_COUNT];
      status[`HBS_ST_EN_LSB +: `HBS_HIGH_COUNT] =
        en_st[NB-1:`HBS_LOW_COUNT];
      status[`HBS_ST_SIDE_LSB +: `HBS_HIGH_COUNT] =
        side_st[NB-1:`HBS_LOW_COUNT];
    end
    else
    begin
      status[`HBS_ST_OCS] = |oc_fl[`HBS_LOW_COUNT-1:0];
      status[`HBS_ST_ULD] = |ul_fl[`HBS_LOW_COUNT-1:0];
      status[`HBS_ST_EN_LSB +: `HBS_LOW_COUNT] =
        en_st[`HBS_LOW_COUNT-1:0];
      status[`HBS_ST_SIDE_LSB +: `HBS_LOW_COUNT] =
        side_st[`HBS_LOW_COUNT-1:0];
    end
  end

  // Next state of phase, serial engine and command word
  always_comb
  begin
    s_nxt        = s_r;
    s_nxt.sclk_d = sclk_s;
    s_nxt.csn_d  = csn_s;
    s_nxt.load   = 1'b0;
    if (!en_s)
    begin
      // Sleep: nothing stored, output released
      s_nxt        = '0;
      s_nxt.sclk_d = sclk_s;
      s_nxt.csn_d  = csn_s;
    end
    else
    begin
      unique case (s_r.phase)
        hbs_pkg::PH_SLEEP:
        begin
          s_nxt.phase   = hbs_pkg::PH_POR;
          s_nxt.por_cnt = 16'h0000;
        end
        hbs_pkg::PH_POR:
        begin
          s_nxt.por_cnt = s_r.por_cnt + 16'h0001;
          if (s_r.por_cnt == 16'(POR_CYCLES - 1))
            s_nxt.phase = hbs_pkg::PH_RUN;
        end
        hbs_pkg::PH_RUN:
        begin
          // Frame start: pseudo-bit at once
          if (csn_fall)
          begin
            s_nxt.in_frame = 1'b1;
            s_nxt.bit_cnt  = 8'h00;
            s_nxt.tx       = status;
            s_nxt.sdo      = s_r.tsd_lat;
            s_nxt.sdo_oe   = 1'b1;
          end
          else if (s_r.in_frame && csn_rise)
          begin
            // Frame end: release output, check and load
            s_nxt.in_frame = 1'b0;
            s_nxt.sdo_oe   = 1'b0;
            s_nxt.sdo      = 1'b0;
            if (frame_ok)
            begin
              s_nxt.cmd  = s_r.rx;
              s_nxt.load = 1'b1;
            end
          end
          else if (s_r.in_frame && sclk_rise)
          begin
            // Next status bit, MSB first
            s_nxt.sdo = s_r.tx[15];
            s_nxt.tx  = {s_r.tx[14:0], 1'b0};
          end
          else if (s_r.in_frame && sclk_fall)
          begin
            // Input bit taken; also feeds the chain behind
            s_nxt.rx    = {s_r.rx[14:0], sdi_s};
            s_nxt.tx[0] = sdi_s;
            if (s_r.bit_cnt != 8'hFF)
              s_nxt.bit_cnt = s_r.bit_cnt + 8'h01;
          end
        end
        default:
          s_nxt.phase = hbs_pkg::PH_SLEEP;
      endcase
      // Thermal shutdown latch; a present fault wins over the clear
      if (srr_pulse && !tsd_s)
        s_nxt.tsd_lat = 1'b0;
      if (tsd_s)
        s_nxt.tsd_lat = 1'b1;
    end
    // Registered copy of the running phase, so the pin comes from a flop
    s_nxt.awake = (s_nxt.phase == hbs_pkg::PH_RUN);
  end

  // Registers; everything zero after reset
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  // Eight channels, two groups
  for (genvar i = 0; i < NB; i++)
  begin : g_bridge
    localparam bit HI = (i >= `HBS_LOW_COUNT);
    localparam int J  = HI ? i - `HBS_LOW_COUNT : i;
    logic sel;
    assign sel = (s_r.cmd[`HBS_CMD_GRP] == HI);
    hbs_bridge u_bridge (
      .clk         (clk),
      .rst_n       (rst_n),
      .sleep       (!en_s),
      .load        (s_r.load && sel),
      .en_in       (s_r.cmd[`HBS_CMD_EN_LSB + J]),
      .side_in     (s_r.cmd[`HBS_CMD_SIDE_LSB + J]),
      .uld_arm_in  (s_r.cmd[`HBS_CMD_ULD]),
      .status_reset_request         (srr_pulse && sel),
      .oc_det      (oc_s[i]),
      .ul_det      (ul_s[i]),
      .lockout     (lockout),
      .hs_on       (high_side_on[i]),
      .ls_on       (low_side_on[i]),
      .en_status   (en_st[i]),
      .side_status (side_st[i]),
      .oc_flag     (oc_fl[i]),
      .ul_flag     (ul_fl[i])
    );
  end

  assign sdo    = s_r.sdo;
  assign sdo_oe = s_r.sdo_oe;
  assign awake  = s_r.awake;

  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence frame_start;
    csn_fall && s_r.phase == hbs_pkg::PH_RUN && en_s;
  endsequence

  sequence frame_end_ok;
    s_r.in_frame && csn_rise && frame_ok && en_s
      && s_r.phase == hbs_pkg::PH_RUN;
  endsequence

  a_sleep_clears: assert property (
    !en_s |=> (s_r.cmd == 16'h0000) && !sdo_oe ##1 (high_side_on == 8'h00)
      && (low_side_on == 8'h00))
    else $error("sleep did not clear state");

  a_por_wait: assert property (
    $rose(en_s) |-> !awake [*8])
    else $error("frames accepted before reset wait");

  a_pre_bit: assert property (
    frame_start |=> sdo_oe && (sdo == $past(s_r.tsd_lat)))
    else $error("pseudo-bit not shown at frame start");

  a_shift_out: assert property (
    s_r.in_frame && sclk_rise && !csn_rise && en_s
      |=> sdo == $past(s_r.tx[15]))
    else $error("status bit not shifted on rising clock");

  a_release_out: assert property (
    s_r.in_frame && csn_rise |=> !sdo_oe)
    else $error("output still driven after frame end");

  a_cmd_load: assert property (
    frame_end_ok |=> s_r.cmd == $past(s_r.rx) ##1 s_r.cmd == $past(s_r.rx, 2))
    else $error("valid frame not loaded");

  a_cmd_keep: assert property (
    s_r.in_frame && csn_rise && !frame_ok && en_s |=> $stable(s_r.cmd))
    else $error("bad frame changed the command");

  a_side_forced: assert property (
    (side_st & ~en_st) == 8'h00)
    else $error("side status set on disabled bridge");

  a_sides_excl: assert property (
    (high_side_on & low_side_on) == 8'h00)
    else $error("both sides of a bridge on");

  a_overvoltage_lockout_enable_off: assert property (
    s_r.cmd[`HBS_CMD_OVERVOLTAGE_LOCKOUT_ENABLE] && ov_s |-> ##[1:2]
      (high_side_on == 8'h00) && (low_side_on == 8'h00))
    else $error("overvoltage lockout did not stop outputs");

  a_tsd_latch: assert property (
    tsd_s && en_s |=> s_r.tsd_lat)
    else $error("thermal shutdown not latched");

  a_tsd_clear: assert property (
    srr_pulse && !tsd_s |=> !s_r.tsd_lat)
    else $error("status reset left thermal latch set");

  a_out_idle: assert property (
    !s_r.in_frame |-> !sdo_oe)
    else $error("output driven outside a frame");

  a_load_once: assert property (
    s_r.load |=> !s_r.load)
    else $error("command load longer than one cycle");

  a_sleep_silent: assert property (
    !awake |=> !sdo_oe)
    else $error("output driven before the port woke");

  a_frame_open: assert property (
    frame_start |=> s_r.in_frame && (s_r.bit_cnt == 8'h00))
    else $error("frame not opened at chip select fall");
endmodule : hbs_top

/* File: hbs_host_model.sv */
// Host controller model: master side of the 16-bit serial frame port.
// Assumes clk is the 200 MHz bench clock; serial clock period 80 ns.
`timescale 1ns/1ps
module hbs_host_model (
  input  wire logic clk,           // Bench clock, paces the link
  output logic      chip_select_n, // Frame select, active low
  output logic      sclk,          // Serial clock, still between frames
  output logic      sdi,           // Command bits to the device
  input  wire logic sdo,           // Status bits from the device
  input  wire logic sdo_oe         // Device drives sdo
);
  // Released output shows the opposite level, so a stray sample shows up
  logic so_line;
  assign so_line = sdo_oe ? sdo : !sdo;

  // Idle levels: select high, clock and data low
  initial
  begin
    chip_select_n = 1'b1;
    sclk          = 1'b0;
    sdi           = 1'b0;
  end

  // Wait n clock edges, then step just past the edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  // One frame of n bits of d, MSB first; returns bits seen on sdo
  task automatic xfer(input logic [31:0] d, input int n,
                      output logic [31:0] r, output logic tsd,
                      output logic oe);
    r = '0;
    tick(1);
    chip_select_n = 1'b0;
    // Select setup interval of 100 ns before first clock
    tick(20);
    tsd = so_line;
    oe  = sdo_oe;
    for (int i = n - 1; i >= 0; i--)
    begin
      // Data changes with the rising clock edge
      sclk = 1'b1;
      sdi  = d[i];
      tick(8);
      r    = {r[30:0], so_line};
      sclk = 1'b0;
      tick(8);
    end
    sdi           = 1'b0;
    chip_select_n = 1'b1;
    // Room for command load and bridge update
    tick(12);
  endtask : xfer
endmodule : hbs_host_model

/* File: hbs_tb.sv */
// Self-checking bench of the half-bridge serial control block.
// Assumes hbs_top and the host model; POR wait shortened to 16 cycles.
`timescale 1ns/1ps
module tb;
  logic        clk;           // 200 MHz clock
  logic        rst_n;         // Logic supply reset
  logic        enable;        // Enable pin
  logic        tsd_det;       // Thermal shutdown detector
  logic        tw_det;        // Thermal warning detector
  logic        uv_det;        // Undervoltage detector
  logic        ov_det;        // Overvoltage detector
  logic [7:0]  oc_det;        // Overcurrent per bridge
  logic [7:0]  ul_det;        // Underload per bridge
  wire         chip_select_n; // From host model
  wire         sclk;          // From host model
  wire         sdi;           // From host model
  logic        sdo;           // Serial out
  logic        sdo_oe;        // Serial out driven
  logic [7:0]  hs;            // High side drives
  logic [7:0]  ls;            // Low side drives
  logic        awake;         // Port serviced
  int          num_errors;    // Mismatches
  int          checks_done;   // Comparisons
  logic [31:0] r;             // Bits seen in last frame
  logic        tsd;           // Pseudo-bit of last frame
  logic        oe;            // Output driven at frame start

  // Clock
  initial clk = 1'b0;
  always #2.5 clk = ~clk;

  hbs_top #(.POR_CYCLES(16)) u_dut (
    .clk(clk), .rst_n(rst_n), .enable(enable),
    .chip_select_n(chip_select_n), .sclk(sclk), .sdi(sdi),
    .tsd_det(tsd_det), .tw_det(tw_det), .uv_det(uv_det),
    .ov_det(ov_det), .oc_det(oc_det), .ul_det(ul_det), .sdo(sdo),
    .sdo_oe(sdo_oe), .high_side_on(hs), .low_side_on(ls),
    .awake(awake)
  );

  hbs_host_model u_host (
    .clk(clk), .chip_select_n(chip_select_n), .sclk(sclk),
    .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe)
  );

  // Count and report one comparison
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : chk

  // Verdict and end of run
  task automatic test_done;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
    begin
      $display("All checks passed");
    end
    else
    begin
      $display("Checks failed");
    end
    $finish;
  endtask : test_done

  // Step n edges, drive just past the edge
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step

  // 16-bit frame; output must be driven at frame start
  task automatic wr16(input logic [15:0] c);
    u_host.xfer({16'h0000, c}, 16, r, tsd, oe);
    chk(oe, 1);
  endtask : wr16

  // Bounded wait for the port to wake
  task automatic wait_awake;
    for (int i = 0; i < 200 && awake !== 1'b1; i++)
      step(1);
    chk(awake, 1);
  endtask : wait_awake

  // Watchdog
  initial
  begin
    repeat (40000) @(posedge clk);
    num_errors++;
    test_done();
  end

  // Main sequence
  initial
  begin
    num_errors = 0;
    checks_done = 0;
    rst_n = 1'b0;
    enable = 1'b1;
    {tsd_det, tw_det, uv_det, ov_det} = 4'h0;
    oc_det = 8'h00;
    ul_det = 8'h00;
    step(16);
    rst_n = 1'b1;
    wait_awake();
    chk({hs, ls}, 0);
    // Low group: all enabled, alternate sides
    wr16(16'h1FD4);
    chk(r[15:0], 16'h0000);
    chk(tsd, 0);
    chk({hs, ls}, {8'h2A, 8'h15});
    // High group programmed, low group kept
    wr16(16'h4182);
    chk(r[15:0], 16'h1FD4);
    chk({hs, ls}, {8'h6A, 8'h95});
    wr16(16'h4182);
    chk(r[15:0], 16'h0182);
    // Short frame is dropped
    u_host.xfer(32'h0, 12, r, tsd, oe);
    chk({hs, ls}, {8'h6A, 8'h95});
    // Long frame keeps last 16 bits and chains sdi through
    u_host.xfer(32'h00AB4006, 24, r, tsd, oe);
    chk(r[23:8], 16'h0182);
    chk(r[7:0], 8'hAB);
    chk({hs, ls}, {8'h2A, 8'h15});
    wr16(16'h1FD4);
    chk(r[15:0], 16'h0000);
    // Overcurrent on bridge 1, then status reset of low group
    oc_det = 8'h01;
    step(20);
    oc_det = 8'h00;
    chk({hs, ls}, {8'h2A, 8'h14});
    wr16(16'h8000);
    chk(r[15:0], 16'h9F54);
    wr16(16'h1FD4);
    chk(r[15:0], 16'h0000);
    chk({hs, ls}, {8'h2A, 8'h15});
    // Armed underload on bridge 2 shuts it down until status reset
    wr16(16'h3FD4);
    ul_det = 8'h02;
    step(20);
    ul_det = 8'h00;
    chk({hs, ls}, {8'h28, 8'h15});
    wr16(16'hBFD4);
    chk(r[15:0], 16'h3ED0);
    chk({hs, ls}, {8'h2A, 8'h15});
    // Overvoltage lockout only when armed
    wr16(16'h1FD5);
    ov_det = 1'b1;
    step(10);
    chk({hs, ls}, 0);
    wr16(16'h1FD4);
    chk(r[15:0] & 16'h4000, 16'h4000);
    chk({hs, ls}, {8'h2A, 8'h15});
    ov_det = 1'b0;
    // Thermal shutdown latch, pseudo-bit, status reset
    tsd_det = 1'b1;
    step(10);
    tsd_det = 1'b0;
    step(10);
    chk({hs, ls}, 0);
    wr16(16'h9FD4);
    chk(tsd, 1);
    tw_det = 1'b1;
    wr16(16'h1FD4);
    chk(tsd, 0);
    chk(r[0], 1);
    tw_det = 1'b0;
    // Enable low clears everything and refuses frames
    enable = 1'b0;
    step(10);
    chk({awake, hs, ls}, 0);
    u_host.xfer(32'h1FD4, 16, r, tsd, oe);
    chk(oe, 0);
    chk(sdo_oe, 0);
    enable = 1'b1;
    wait_awake();
    wr16(16'h0000);
    chk(r[15:0], 16'h0000);
    chk({tsd, hs, ls}, 0);
    test_done();
  end
endmodule : tb
